// File: design/sadc_pkg.sv
// constants, types and lookup helpers for the converter control block
// assumes a 32-bit apb slave at 50 MHz, byte address = 4 * register index
package sadc_pkg;
	// apb shape and clock
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned CLK_PERIOD_NS = 20;
	// register indexes; byte address is four times these
	localparam logic [9:0] CTRL_IDX = 10'h01f;
	localparam logic [9:0] PINCFG_IDX = 10'h09f;
	localparam logic [9:0] RES_HI_IDX = 10'h01e;
	localparam logic [9:0] RES_LO_IDX = 10'h09e;
	localparam logic [9:0] INT_STAT_IDX = 10'h0c0;
	localparam logic [9:0] INT_MASK_IDX = 10'h0c1;
	// converter_control fields
	localparam int unsigned CLK_SEL_POS = 6;
	localparam int unsigned CHAN_POS = 3;
	localparam int unsigned GO_POS = 2;
	localparam int unsigned ON_POS = 0;
	// pin_config_control fields
	localparam int unsigned JUSTIFY_POS = 7;
	localparam int unsigned PCFG_POS = 0;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PINCFG_RST = 8'h00;
	localparam logic [7:0] INT_MASK_RST = 8'h00;
	// conversion timing
	localparam int unsigned RES_BITS = 10;
	localparam logic [5:0] DIV_FOSC2 = 6'h02;
	localparam logic [5:0] DIV_FOSC8 = 6'h08;
	localparam logic [5:0] DIV_FOSC32 = 6'h20;
	localparam logic [7:0] SMALL_CHAN_MASK = 8'h1f;
	// conversion clock sources
	typedef enum logic [1:0] {
		SADC_FOSC2 = 2'b00, SADC_FOSC8 = 2'b01, SADC_FOSC32 = 2'b10, SADC_RC = 2'b11
	} sadc_clk_t;
	// approximation engine states, one-hot
	typedef enum logic [2:0] {
		SADC_IDLE = 3'b001, SADC_HOLD = 3'b010, SADC_BITS = 3'b100
	} sadc_sar_t;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	// pin map: {neg ref on pin, pos ref on pin, analog input mask}
	function automatic logic [9:0] pin_map(input logic [3:0] cfg);
		case (cfg)
			4'h0: pin_map = 10'h0ff;
			4'h1: pin_map = 10'h1f7;
			4'h2: pin_map = 10'h01f;
			4'h3: pin_map = 10'h117;
			4'h4: pin_map = 10'h00b;
			4'h5: pin_map = 10'h103;
			4'h6, 4'h7: pin_map = 10'h000;
			4'h8: pin_map = 10'h3f3;
			4'h9: pin_map = 10'h03f;
			4'ha: pin_map = 10'h137;
			4'hb: pin_map = 10'h333;
			4'hc: pin_map = 10'h313;
			4'hd: pin_map = 10'h303;
			4'he: pin_map = 10'h001;
			default: pin_map = 10'h301;
		endcase
	endfunction
endpackage

// File: design/sadc_conv_if.sv
// signals shared by the control, bit-clock and approximation modules
// assumes all three run on pclk
`timescale 1ns/1ps
`default_nettype none
interface sadc_conv_if;
	logic [1:0] clk_sel;
	logic sleep_mode;
	logic rc_tick;
	logic tad_tick;
	logic start;
	logic abort;
	logic busy;
	logic done;
	logic cmp_in;
	logic [9:0] result;
	logic [9:0] trial;
	modport ctl (output clk_sel, sleep_mode, rc_tick, start, abort, cmp_in,
		input tad_tick, busy, done, result, trial);
	modport tad (input clk_sel, sleep_mode, rc_tick, busy, output tad_tick);
	modport sar (input tad_tick, start, abort, cmp_in, output busy, done, result, trial);
endinterface
`default_nettype wire

// File: design/sadc_tad_gen.sv
// bit period tick generator: divided pclk or the internal rc tick
// assumes rc_tick is a one-cycle pulse already synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module sadc_tad_gen (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// converter side
	sadc_conv_if.tad c
);
	logic [5:0] cnt_r, cnt_nxt, div;
	logic tick_r, tick_nxt;
	logic stall;

	// sleep stops the oscillator, so only the rc source keeps ticking
	always_comb begin
		case (sadc_pkg::sadc_clk_t'(c.clk_sel))
			sadc_pkg::SADC_FOSC2: div = sadc_pkg::DIV_FOSC2;
			sadc_pkg::SADC_FOSC8: div = sadc_pkg::DIV_FOSC8;
			default: div = sadc_pkg::DIV_FOSC32;
		endcase
		stall = c.sleep_mode && (c.clk_sel != sadc_pkg::SADC_RC);
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!c.busy || stall) begin
			cnt_nxt = 6'h00;
		end else if (c.clk_sel == sadc_pkg::SADC_RC) begin
			tick_nxt = c.rc_tick;
		end else if (cnt_r == div - 6'h01) begin
			cnt_nxt = 6'h00;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 6'h01;
		end
	end

	// counter and tick registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 6'h00;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign c.tad_tick = tick_r;

	chk_tad_fosc8: assert property (@(posedge pclk) disable iff (!presetn)
		tick_r && c.clk_sel == sadc_pkg::SADC_FOSC8 && !c.sleep_mode && $stable(c.clk_sel)
		|=> !tick_r [*7]) else $error("bit tick faster than fosc/8");
	chk_sleep_stall: assert property (@(posedge pclk) disable iff (!presetn)
		stall |=> !tick_r) else $error("bit tick during sleep without rc source");
endmodule
`default_nettype wire

// File: design/sadc_sar.sv
// successive approximation sequencer: one hold period, then ten bit trials
// assumes cmp_in is high when the held input is at or above the trial code
`timescale 1ns/1ps
`default_nettype none
module sadc_sar (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// converter side
	sadc_conv_if.sar c
);
	sadc_pkg::sadc_sar_t st_r, st_nxt;
	logic [9:0] trial_r, trial_nxt, res_r, res_nxt;
	logic [3:0] idx_r, idx_nxt;
	logic done_r, done_nxt;
	logic [9:0] kept;

	// one bit decided per tick, msb first
	always_comb begin
		st_nxt = st_r;
		trial_nxt = trial_r;
		res_nxt = res_r;
		idx_nxt = idx_r;
		done_nxt = 1'b0;
		kept = c.cmp_in ? trial_r : (trial_r & ~(10'h001 << idx_r));
		case (st_r)
			sadc_pkg::SADC_IDLE: begin
				if (c.start) begin
					st_nxt = sadc_pkg::SADC_HOLD;
					trial_nxt = 10'h000;
				end
			end
			sadc_pkg::SADC_HOLD: begin
				if (c.tad_tick) begin
					st_nxt = sadc_pkg::SADC_BITS;
					trial_nxt = 10'h200;
					idx_nxt = 4'h9;
				end
			end
			sadc_pkg::SADC_BITS: begin
				if (c.tad_tick) begin
					if (idx_r == 4'h0) begin
						st_nxt = sadc_pkg::SADC_IDLE;
						res_nxt = kept;
						trial_nxt = kept;
						done_nxt = 1'b1;
					end else begin
						trial_nxt = kept | (10'h001 << (idx_r - 4'h1));
						idx_nxt = idx_r - 4'h1;
					end
				end
			end
			default: st_nxt = sadc_pkg::SADC_IDLE;
		endcase
		// an abort drops the conversion without a result
		if (c.abort) begin
			st_nxt = sadc_pkg::SADC_IDLE;
			done_nxt = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= sadc_pkg::SADC_IDLE;
			trial_r <= 10'h000;
			res_r <= 10'h000;
			idx_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			trial_r <= trial_nxt;
			res_r <= res_nxt;
			idx_r <= idx_nxt;
			done_r <= done_nxt;
		end
	end
	assign c.busy = (st_r != sadc_pkg::SADC_IDLE);
	assign c.done = done_r;
	assign c.result = res_r;
	assign c.trial = trial_r;
endmodule
`default_nettype wire

// File: design/sadc_ctrl.sv
// top of the converter control: apb registers, interrupt, analog controls
// assumes a 32-bit apb master on pclk and synchronous analog side inputs
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sadc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device state and rc oscillator
	input wire logic sleep_mode,
	input wire logic rc_tick,
	// analog front end
	input wire logic cmp_in,
	output logic conv_power,
	output logic sample_en,
	output logic [2:0] input_channel_select,
	output logic [9:0] dac_code,
	output logic pos_ref_pin_sel,
	output logic neg_ref_pin_sel,
	output logic [7:0] pin_analog,
	// interrupt
	output logic irq
);
	sadc_conv_if c ();

	// bit clock and approximation engine
	sadc_tad_gen u_tad (
		.pclk(pclk),
		.presetn(presetn),
		.c(c.tad)
	);
	sadc_sar u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.c(c.sar)
	);

	// software visible state
	logic [1:0] clk_sel_r, clk_sel_nxt;
	logic [2:0] chan_r, chan_nxt;
	logic on_r, on_nxt;
	logic justify_r, justify_nxt;
	logic [3:0] pcfg_r, pcfg_nxt;
	logic [9:0] res_r, res_nxt;
	logic stat_r, stat_nxt;
	logic mask_r, mask_nxt;
	logic start_r, start_nxt;
	logic abort_r, abort_nxt;
	// bus answer
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	// analog side outputs
	logic sample_r, sample_nxt;
	logic [7:0] pin_analog_r, pin_analog_nxt;
	logic pos_ref_r, pos_ref_nxt;
	logic neg_ref_r, neg_ref_nxt;
	logic irq_r, irq_nxt;
	// decode helpers
	logic access, wr_done, rd_done, hit;
	logic [9:0] map;
	logic [7:0] rd_byte;
	logic go_view;

	// hand the converter its controls
	assign c.clk_sel = clk_sel_r;
	assign c.sleep_mode = sleep_mode;
	assign c.rc_tick = rc_tick;
	assign c.start = start_r;
	assign c.abort = abort_r;
	assign c.cmp_in = cmp_in;

	// one wait state: data is registered in the first access cycle
	assign access = psel && penable;
	assign wr_done = access && pready_r && pwrite;
	assign rd_done = access && pready_r && !pwrite;
	assign go_view = start_r || c.busy;

	function automatic logic addr_is(input logic [sadc_pkg::ADDR_W-1:0] a, input logic [9:0] idx);
		addr_is = (a == sadc_pkg::byte_addr(idx));
	endfunction

	// read mux and address decode
	always_comb begin
		hit = 1'b1;
		rd_byte = 8'h00;
		if (addr_is(paddr, sadc_pkg::CTRL_IDX)) begin
			rd_byte = {clk_sel_r, chan_r, go_view, 1'b0, on_r};
		end else if (addr_is(paddr, sadc_pkg::PINCFG_IDX)) begin
			rd_byte = {justify_r, 3'b000, pcfg_r};
		end else if (addr_is(paddr, sadc_pkg::RES_HI_IDX)) begin
			rd_byte = justify_r ? {6'h00, res_r[9:8]} : res_r[9:2];
		end else if (addr_is(paddr, sadc_pkg::RES_LO_IDX)) begin
			rd_byte = justify_r ? res_r[7:0] : {res_r[1:0], 6'h00};
		end else if (addr_is(paddr, sadc_pkg::INT_STAT_IDX)) begin
			rd_byte = {7'h00, stat_r};
		end else if (addr_is(paddr, sadc_pkg::INT_MASK_IDX)) begin
			rd_byte = {7'h00, mask_r};
		end else begin
			hit = 1'b0;
		end
	end

	// bus answer: ready one cycle into the access phase
	always_comb begin
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (access && !pready_r) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !hit;
			prdata_nxt = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end
	end

	// register writes, conversion start and stop
	always_comb begin
		clk_sel_nxt = clk_sel_r;
		chan_nxt = chan_r;
		on_nxt = on_r;
		justify_nxt = justify_r;
		pcfg_nxt = pcfg_r;
		mask_nxt = mask_r;
		start_nxt = 1'b0;
		abort_nxt = 1'b0;
		if (wr_done && hit && addr_is(paddr, sadc_pkg::CTRL_IDX)) begin
			clk_sel_nxt = pwdata[sadc_pkg::CLK_SEL_POS +: 2];
			chan_nxt = pwdata[sadc_pkg::CHAN_POS +: 3];
			on_nxt = pwdata[sadc_pkg::ON_POS];
			// go only counts when already powered, so power must settle first
			if (pwdata[sadc_pkg::GO_POS] && on_r && pwdata[sadc_pkg::ON_POS] && !go_view) begin
				start_nxt = 1'b1;
			end
			// clearing go mid conversion, or powering off, drops it
			if (go_view && (!pwdata[sadc_pkg::GO_POS] || !pwdata[sadc_pkg::ON_POS])) begin
				abort_nxt = 1'b1;
			end
		end
		if (wr_done && addr_is(paddr, sadc_pkg::PINCFG_IDX)) begin
			justify_nxt = pwdata[sadc_pkg::JUSTIFY_POS];
			pcfg_nxt = pwdata[sadc_pkg::PCFG_POS +: 4];
		end
		if (wr_done && addr_is(paddr, sadc_pkg::INT_MASK_IDX)) begin
			mask_nxt = pwdata[0];
		end
	end

	// result capture, done flag and interrupt; a new done beats a read clear
	always_comb begin
		res_nxt = c.done ? c.result : res_r;
		stat_nxt = stat_r;
		if (rd_done && addr_is(paddr, sadc_pkg::INT_STAT_IDX)) begin
			stat_nxt = 1'b0;
		end
		if (c.done) begin
			stat_nxt = 1'b1;
		end
		irq_nxt = stat_nxt && mask_r;
	end

	// analog side controls; absent channels read back digital on the small part
	always_comb begin
		map = sadc_pkg::pin_map(pcfg_r);
		pin_analog_nxt = LARGE_VARIANT ? map[7:0] : (map[7:0] & sadc_pkg::SMALL_CHAN_MASK);
		pos_ref_nxt = map[8];
		neg_ref_nxt = map[9];
		sample_nxt = on_r && !c.busy && !start_r;
	end

	// all state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_r <= sadc_pkg::CTRL_RST[sadc_pkg::CLK_SEL_POS +: 2];
			chan_r <= sadc_pkg::CTRL_RST[sadc_pkg::CHAN_POS +: 3];
			on_r <= sadc_pkg::CTRL_RST[sadc_pkg::ON_POS];
			justify_r <= sadc_pkg::PINCFG_RST[sadc_pkg::JUSTIFY_POS];
			pcfg_r <= sadc_pkg::PINCFG_RST[sadc_pkg::PCFG_POS +: 4];
			mask_r <= sadc_pkg::INT_MASK_RST[0];
			res_r <= 10'h000;
			stat_r <= 1'b0;
			start_r <= 1'b0;
			abort_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			sample_r <= 1'b0;
			pin_analog_r <= 8'h00;
			pos_ref_r <= 1'b0;
			neg_ref_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			clk_sel_r <= clk_sel_nxt;
			chan_r <= chan_nxt;
			on_r <= on_nxt;
			justify_r <= justify_nxt;
			pcfg_r <= pcfg_nxt;
			mask_r <= mask_nxt;
			res_r <= res_nxt;
			stat_r <= stat_nxt;
			start_r <= start_nxt;
			abort_r <= abort_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			sample_r <= sample_nxt;
			pin_analog_r <= pin_analog_nxt;
			pos_ref_r <= pos_ref_nxt;
			neg_ref_r <= neg_ref_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ports straight from flip-flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign conv_power = on_r;
	assign sample_en = sample_r;
	assign input_channel_select = chan_r;
	assign dac_code = c.trial; // trial code is a register of the engine
	assign pos_ref_pin_sel = pos_ref_r;
	assign neg_ref_pin_sel = neg_ref_r;
	assign pin_analog = pin_analog_r;
	assign irq = irq_r;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start;
		start_r && on_r ##1 c.busy;
	endsequence
	sequence s_finish;
		c.done ##1 (!c.busy && !start_r && stat_r);
	endsequence

	chk_start_powered: assert property (start_r |-> s_start)
		else $error("conversion start without power or without going busy");
	chk_done_clears: assert property (c.done |-> s_finish)
		else $error("completion did not clear go or set the done flag");
	chk_result_load: assert property (c.done |=> res_r == $past(c.result))
		else $error("result not loaded on completion");
	chk_power_off: assert property ($fell(on_r) |-> ##[0:2] !c.busy)
		else $error("conversion kept running after power off");
	chk_chan_write: assert property (wr_done && hit && addr_is(paddr, sadc_pkg::CTRL_IDX)
		|=> input_channel_select == $past(pwdata[5:3]) && clk_sel_r == $past(pwdata[7:6]))
		else $error("channel or clock select not taken from write");
	// the first edge after reset release still shows the reset value, so skip it
	chk_pin_map: assert property (##1 $stable(pcfg_r) && $past(presetn) |-> pin_analog_r[4:0] == $past(map[4:0])
		&& pos_ref_r == $past(map[8]) && neg_ref_r == $past(map[9]))
		else $error("pin configuration outputs disagree with map");
	chk_small_part: assert property (!LARGE_VARIANT |-> pin_analog_r[7:5] == 3'b000)
		else $error("absent channel shown analog on small variant");
	chk_justify: assert property (rd_done && justify_r && addr_is(paddr, sadc_pkg::RES_HI_IDX)
		|-> prdata_r[7:2] == 6'h00)
		else $error("right justified high byte has upper bits set");
	chk_irq_level: assert property (c.done && mask_r |-> ##1 irq_r)
		else $error("masked-in completion did not raise interrupt");
endmodule
`default_nettype wire

// File: test/sadc_afe_model.sv
// analog front end model: sample-and-hold plus comparator
// assumes dac_code and sample_en are registered on pclk
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model (
	// clock
	input wire logic pclk,
	// from the converter
	input wire logic conv_power,
	input wire logic sample_en,
	input wire logic [9:0] dac_code,
	// level set by the bench
	input wire logic [9:0] level,
	// comparator out
	output logic cmp_in
);
	logic [9:0] held_r;

	// track while acquiring, hold once the conversion begins
	always_ff @(posedge pclk) begin
		if (sample_en)
			held_r <= level;
	end

	// unpowered comparator gives no stable answer, so it wobbles
	assign cmp_in = conv_power ? (held_r >= dac_code) : (level[0] ^ dac_code[0]);
endmodule
`default_nettype wire

// File: test/sar_adc_control_bench.sv
// self-checking bench for the converter control, apb master plus level model
// assumes the default eight-input variant and a one-wait-state apb slave
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, rc_tick, cmp_in, er;
	logic conv_power, sample_en, pos_ref_pin_sel, neg_ref_pin_sel, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] input_channel_select;
	logic [9:0] dac_code, level;
	logic [7:0] pin_analog, pin_small;
	int err_total, checked, rc_n;
	int exp_q[$];
	localparam logic [11:0] A_CTRL = {sadc_pkg::CTRL_IDX, 2'b00};
	localparam logic [11:0] A_PIN = {sadc_pkg::PINCFG_IDX, 2'b00};
	localparam logic [11:0] A_HI = {sadc_pkg::RES_HI_IDX, 2'b00};
	localparam logic [11:0] A_LO = {sadc_pkg::RES_LO_IDX, 2'b00};
	localparam logic [11:0] A_STAT = {sadc_pkg::INT_STAT_IDX, 2'b00};
	localparam logic [11:0] A_MASK = {sadc_pkg::INT_MASK_IDX, 2'b00};
	// analog pins per config code, reference pins left out
	localparam logic [7:0] AMAP [16] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00,
		8'hf3, 8'h3f, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
	localparam logic [15:0] POS_REF = 16'hbd2a;
	localparam logic [15:0] NEG_REF = 16'hb900;

	sadc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_mode(sleep_mode), .rc_tick(rc_tick), .cmp_in(cmp_in), .conv_power(conv_power),
		.sample_en(sample_en), .input_channel_select(input_channel_select), .dac_code(dac_code),
		.pos_ref_pin_sel(pos_ref_pin_sel), .neg_ref_pin_sel(neg_ref_pin_sel), .pin_analog(pin_analog),
		.irq(irq));
	sadc_afe_model u_afe (.pclk(pclk), .conv_power(conv_power), .sample_en(sample_en),
		.dac_code(dac_code), .level(level), .cmp_in(cmp_in));
	// five-input variant on the same bus, only its pin map is looked at
	sadc_ctrl #(.LARGE_VARIANT(1'b0)) u_small (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.sleep_mode(sleep_mode), .rc_tick(rc_tick), .cmp_in(cmp_in), .conv_power(), .sample_en(),
		.input_channel_select(), .dac_code(), .pos_ref_pin_sel(), .neg_ref_pin_sel(), .pin_analog(pin_small),
		.irq());

	// clock at 50 MHz
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// internal rc tick, one pulse every five cycles
	always @(posedge pclk) begin
		rc_n <= (rc_n == 4) ? 0 : rc_n + 1;
		rc_tick <= (rc_n == 4);
	end

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; holds everything until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			err_total++;
			conclude();
		end
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// bounded wait for the level interrupt
	task automatic wait_irq;
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 3000) begin
			err_total++;
			conclude();
		end
	endtask

	// one full conversion: clock select, channel and justification from i
	task automatic conv(input int i);
		int cs, j, r;
		logic [7:0] ctl;
		cs = i % 4;
		j = i % 2;
		r = $urandom % 1024;
		exp_q.push_back(r);
		level <= r[9:0];
		sleep_mode <= (cs == 3);
		ctl = 8'(cs << 6 | i << 3 | 1);
		apb(1'b1, A_PIN, 32'(j << 7));
		apb(1'b1, A_CTRL, {24'h0, ctl});
		apb(1'b1, A_CTRL, {24'h0, ctl | 8'h04});
		rchk(A_CTRL, {24'h0, ctl | 8'h04});
		wait_irq();
		r = exp_q.pop_front();
		chk(dac_code, r);
		chk(input_channel_select, i);
		rchk(A_CTRL, {24'h0, ctl});
		rchk(A_HI, j ? r >> 8 : r >> 2);
		rchk(A_LO, j ? r & 255 : (r & 3) << 6);
		rchk(A_STAT, 1);
		rchk(A_STAT, 0);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		sleep_mode <= 1'b0;
		repeat (64) @(posedge pclk);
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		conclude();
	end

	initial begin
		{presetn, psel, penable, pwrite, sleep_mode} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		level = 10'h0;
		void'($urandom(32'h1f67));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values and an unmapped place
		rchk(A_CTRL, 0);
		rchk(A_PIN, 0);
		rchk(A_MASK, 0);
		apb(1'b1, 12'h010, 32'h55);
		chk(er, 1);
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 1);
		chk(rd, 0);
		// every pin configuration code, upper bits must not stick
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, A_PIN, 32'h70 | c);
			repeat (2) @(posedge pclk);
			chk(pin_analog, AMAP[c]);
			chk(pin_small, AMAP[c] & 8'h1f);
			chk(pos_ref_pin_sel, POS_REF[c]);
			chk(neg_ref_pin_sel, NEG_REF[c]);
			rchk(A_PIN, c);
		end
		apb(1'b1, A_MASK, 32'h1);
		rchk(A_MASK, 1);
		for (int i = 0; i < 8; i++)
			conv(i);
		// go from powered-off is refused
		apb(1'b1, A_CTRL, 32'h0);
		apb(1'b1, A_CTRL, 32'h04);
		rchk(A_CTRL, 0);
		chk(conv_power, 0);
		// power off in mid-conversion aborts with no flag
		apb(1'b1, A_CTRL, 32'h81);
		apb(1'b1, A_CTRL, 32'h85);
		apb(1'b1, A_CTRL, 32'h0);
		repeat (400) @(posedge pclk);
		chk({irq, conv_power}, 0);
		rchk(A_STAT, 0);
		// sleep without the rc source freezes the conversion until wake
		level <= 10'h2a5;
		apb(1'b1, A_CTRL, 32'h01);
		sleep_mode <= 1'b1;
		apb(1'b1, A_CTRL, 32'h05);
		repeat (100) @(posedge pclk);
		rchk(A_CTRL, 32'h05);
		chk(irq, 0);
		sleep_mode <= 1'b0;
		wait_irq();
		chk(dac_code, 10'h2a5);
		rchk(A_STAT, 1);
		// masked completion sets the flag but keeps irq low
		apb(1'b1, A_MASK, 32'h0);
		apb(1'b1, A_CTRL, 32'h01);
		apb(1'b1, A_CTRL, 32'h05);
		repeat (60) @(posedge pclk);
		chk(irq, 0);
		rchk(A_STAT, 1);
		conclude();
	end
endmodule
`default_nettype wire
